// ==== logic/pdpc_defines.svh ====
// Constants for the port direction and pad-control block.
// Assumes a 32-bit AXI4-Lite register bus; each index is a word.
`ifndef PDPC_DEFINES_SVH
`define PDPC_DEFINES_SVH

// Register indices; byte address is four times the index
`define PDPC_IDX_DATA     16'hF230
`define PDPC_IDX_DIR      16'hF231
`define PDPC_IDX_CON      16'hF232
`define PDPC_IDX_CON_HI   16'hF233
`define PDPC_IDX_FSEL     16'hF234
`define PDPC_IDX_FSEL_HI  16'hF235

// Reset values
`define PDPC_RST_DATA     8'h00
`define PDPC_RST_DIR      8'h00
`define PDPC_RST_CON      16'h0000
`define PDPC_RST_FSEL     16'h0000

// Field positions
`define PDPC_CODE_HI_OFS  8
`define PDPC_FSEL_GPIO    2'h0

// Direction encodings
`define PDPC_DIR_OUT      1'b0
`define PDPC_DIR_IN       1'b1

// Bus responses
`define PDPC_RESP_OKAY    2'h0
`define PDPC_RESP_SLVERR  2'h2

`endif

// ==== logic/pdpc_pad_cell.sv ====
// One pin's pad decoder with registered enables.
// Assumes settings arrive from the register file of pdpc_port.
`include "pdpc_defines.svh"

module pdpc_pad_cell
    import pdpc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       dir,
    input  wire logic [1:0] code,
    input  wire logic       data,
    input  wire logic [1:0] fsel,
    input  wire logic       alt_out,
    input  wire logic       alt_out_en,
    output logic            pad_o,
    output logic            pad_oe,
    output logic            pull_up_en,
    output logic            pull_down_en,
    output logic            drive_hi_en,
    output logic            drive_lo_en
);

    logic hi_d, lo_d, pu_d, pd_d;   // Next enables
    pdpc_code_t code_e;             // Typed view of the code

    ////////////////////////////////////////////////////////////////
    // Decode settings into driver and pull enables
    always_comb begin
        code_e = pdpc_code_t'(code);
        hi_d   = 1'b0;
        lo_d   = 1'b0;
        pu_d   = 1'b0;
        pd_d   = 1'b0;
        if (fsel != `PDPC_FSEL_GPIO) begin
            // Alternate function owns the pin; push-pull only
            hi_d = alt_out_en & alt_out;
            lo_d = alt_out_en & ~alt_out;
        end else if (dir == `PDPC_DIR_OUT) begin
            unique case (code_e)
                PDPC_CODE_HIZ: ;
                PDPC_CODE_PCH: hi_d = data;
                PDPC_CODE_NCH: lo_d = ~data;
                PDPC_CODE_CMOS: begin
                    hi_d = data;
                    lo_d = ~data;
                end
            endcase
        end else begin
            unique case (code_e)
                PDPC_CODE_PCH: pd_d = 1'b1;
                PDPC_CODE_NCH: pu_d = 1'b1;
                PDPC_CODE_HIZ, PDPC_CODE_CMOS: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register the enables so pads never see decode glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_hi_en  <= 1'b0;
            drive_lo_en  <= 1'b0;
            pull_up_en   <= 1'b0;
            pull_down_en <= 1'b0;
        end else begin
            drive_hi_en  <= hi_d;
            drive_lo_en  <= lo_d;
            pull_up_en   <= pu_d;
            pull_down_en <= pd_d;
        end
    end

    // Only one side ever drives, so the level is the high enable
    assign pad_o  = drive_hi_en;
    assign pad_oe = drive_hi_en | drive_lo_en;

endmodule : pdpc_pad_cell

// ==== logic/pdpc_pkg.sv ====
// Types shared by the port direction and pad-control block.
// Assumes pdpc_defines.svh is on the include path.
package pdpc_pkg;

    // Two-bit drive code of one pin
    typedef enum logic [1:0] {
        PDPC_CODE_HIZ  = 2'h0,  // Hi-Z out / hi-Z in
        PDPC_CODE_PCH  = 2'h1,  // P-channel out / pull-down in
        PDPC_CODE_NCH  = 2'h2,  // N-channel out / pull-up in
        PDPC_CODE_CMOS = 2'h3   // Push-pull out / hi-Z in
    } pdpc_code_t;

endpackage : pdpc_pkg

// ==== logic/pdpc_port.sv ====
// Eight-pin port: direction, pad control, data and function select
// registers behind an AXI4-Lite slave, plus one pad decoder per pin.
// Assumes pad_i is already synchronous to aclk and that the
// alternate-function peripherals supply alt_out and alt_out_en.
//
// The AXI4-Lite interface to the registers was decided locally.
`include "pdpc_defines.svh"

module pdpc_port
    import pdpc_pkg::*;
#(
    parameter int ADDR_W = 18,  // Covers index 0xF235 times four
    parameter int PINS   = 8    // Pins of the port
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // Write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // Write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // Read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Alternate-function drive from peripherals
    input  wire logic [PINS-1:0]   alt_out,
    input  wire logic [PINS-1:0]   alt_out_en,
    // Pads
    input  wire logic [PINS-1:0]   pad_i,
    output logic [PINS-1:0]        pad_o,
    output logic [PINS-1:0]        pad_oe,
    output logic [PINS-1:0]        pull_up_en,
    output logic [PINS-1:0]        pull_down_en,
    output logic [PINS-1:0]        drive_hi_en,
    output logic [PINS-1:0]        drive_lo_en
);

    ////////////////////////////////////////////////////////////////
    // Register state
    // Every register clears on the synchronous reset
    logic [PINS-1:0]   data_q;    // Port data value
    logic [PINS-1:0]   dir_q;     // Pin direction
    logic [2*PINS-1:0] con_q;     // Pad drive control
    logic [2*PINS-1:0] fsel_q;    // Pin function select

    // Write channel holding state
    logic [ADDR_W-1:0] aw_addr_q; // Latched write address
    logic              aw_got_q;  // Address held
    logic [31:0]       w_data_q;  // Latched write data
    logic [3:0]        w_strb_q;  // Latched strobes
    logic              w_got_q;   // Data held
    logic              bvalid_q;  // Response pending
    logic [1:0]        bresp_q;   // Response code

    // Read channel state
    logic              rvalid_q;  // Read data pending
    logic [31:0]       rdata_q;   // Read data
    logic [1:0]        rresp_q;   // Read response

    // Commit strobe: address and data both held, response slot free
    logic              do_write;  // Both halves present

    ////////////////////////////////////////////////////////////////
    // Functions

    // True when a byte address selects the given register index
    // Address bits 1:0 are ignored, so every access names a whole word
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction : hit

    // True when a byte address selects any mapped register
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, `PDPC_IDX_DATA)  | hit(a, `PDPC_IDX_DIR)  |
                 hit(a, `PDPC_IDX_CON)   | hit(a, `PDPC_IDX_CON_HI) |
                 hit(a, `PDPC_IDX_FSEL)  | hit(a, `PDPC_IDX_FSEL_HI);
    endfunction : mapped

    // Replace one byte of old when its strobe is set
    // Bytes without a strobe keep their stored value
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic       en);
        merge = en ? new_v : old_v;
    endfunction : merge

    // Readback of the data register: stored value for outputs,
    // sampled level for inputs
    function automatic logic [7:0] data_view(input logic [7:0] d,
                                             input logic [7:0] dr,
                                             input logic [7:0] p);
        data_view = (d & ~dr) | (p & dr);
    endfunction : data_view

    // Read mux over all mapped indices; narrow data in low bits
    // Unmapped addresses read as zero with an error response
    function automatic logic [31:0] rd_word(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        d,
        input logic [7:0]        dr,
        input logic [15:0]       c,
        input logic [15:0]       f,
        input logic [7:0]        p
    );
        rd_word = 32'h00000000;
        if (hit(a, `PDPC_IDX_DATA))
            rd_word = {24'h000000, data_view(d, dr, p)};
        else if (hit(a, `PDPC_IDX_DIR))
            rd_word = {24'h000000, dr};
        else if (hit(a, `PDPC_IDX_CON))
            rd_word = {16'h0000, c};
        else if (hit(a, `PDPC_IDX_CON_HI))
            rd_word = {24'h000000, c[15:8]};
        else if (hit(a, `PDPC_IDX_FSEL))
            rd_word = {16'h0000, f};
        else if (hit(a, `PDPC_IDX_FSEL_HI))
            rd_word = {24'h000000, f[15:8]};
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////
    // Write address and data are taken independently, in any order
    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready  = !w_got_q;
    // Commit waits for a free response slot
    assign do_write      = aw_got_q & w_got_q & !bvalid_q;

    // Address holding register; the slot frees on the commit edge, so a
    // master that re-offers at once sees one idle cycle between writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got_q  <= 1'b0;
        end
    end

    // Data holding register; kept apart from the address so either
    // channel may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q  <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_got_q  <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    // No commit starts while an answer is pending, so the response
    // slot is never overwritten before the master has taken it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `PDPC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(aw_addr_q) ? `PDPC_RESP_OKAY
                                          : `PDPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    ////////////////////////////////////////////////////////////////
    // Data register; stored even in input mode for later output
    // Only the low strobe matters: the register is one byte wide
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `PDPC_RST_DATA;
        end else if (do_write && hit(aw_addr_q, `PDPC_IDX_DATA)) begin
            data_q <= merge(data_q, w_data_q[7:0], w_strb_q[0]);
        end
    end

    // Direction register, one bit per pin
    // Reset leaves every pin an output with its drivers off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= `PDPC_RST_DIR;
        end else if (do_write && hit(aw_addr_q, `PDPC_IDX_DIR)) begin
            dir_q <= merge(dir_q, w_data_q[7:0], w_strb_q[0]);
        end
    end

    // Pad control: halfword at its base, byte at either index
    // The high-byte index is the same storage as bits 15:8, so a byte
    // write there and a halfword write here can never disagree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            con_q <= `PDPC_RST_CON;
        end else if (do_write) begin
            if (hit(aw_addr_q, `PDPC_IDX_CON)) begin
                con_q[7:0]  <= merge(con_q[7:0], w_data_q[7:0],
                                     w_strb_q[0]);
                con_q[15:8] <= merge(con_q[15:8], w_data_q[15:8],
                                     w_strb_q[1]);
            end else if (hit(aw_addr_q, `PDPC_IDX_CON_HI)) begin
                con_q[15:8] <= merge(con_q[15:8], w_data_q[7:0],
                                     w_strb_q[0]);
            end
        end
    end

    // Function select: same halfword/byte arrangement
    // Code 00 on a pin leaves it to the direction and pad-control logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fsel_q <= `PDPC_RST_FSEL;
        end else if (do_write) begin
            if (hit(aw_addr_q, `PDPC_IDX_FSEL)) begin
                fsel_q[7:0]  <= merge(fsel_q[7:0], w_data_q[7:0],
                                      w_strb_q[0]);
                fsel_q[15:8] <= merge(fsel_q[15:8], w_data_q[15:8],
                                      w_strb_q[1]);
            end else if (hit(aw_addr_q, `PDPC_IDX_FSEL_HI)) begin
                fsel_q[15:8] <= merge(fsel_q[15:8], w_data_q[7:0],
                                      w_strb_q[0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, data one edge after address
    // Data are captured at the address edge, so an input pin returns
    // its level at that edge, not at the edge the master takes it
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `PDPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word(s_axi_araddr, data_q, dir_q,
                                con_q, fsel_q, pad_i);
            rresp_q  <= mapped(s_axi_araddr) ? `PDPC_RESP_OKAY
                                             : `PDPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    ////////////////////////////////////////////////////////////////
    // One pad decoder per pin; pin n uses bits n and n+8
    // Each cell registers its enables, so pads change one edge after
    // the register write that caused them
    for (genvar n = 0; n < PINS; n++) begin : g_pin
        pdpc_pad_cell u_cell (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .dir          (dir_q[n]),
            .code         ({con_q[n+`PDPC_CODE_HI_OFS],
                            con_q[n]}),
            .data         (data_q[n]),
            .fsel         ({fsel_q[n+`PDPC_CODE_HI_OFS],
                            fsel_q[n]}),
            .alt_out      (alt_out[n]),
            .alt_out_en   (alt_out_en[n]),
            .pad_o        (pad_o[n]),
            .pad_oe       (pad_oe[n]),
            .pull_up_en   (pull_up_en[n]),
            .pull_down_en (pull_down_en[n]),
            .drive_hi_en  (drive_hi_en[n]),
            .drive_lo_en  (drive_lo_en[n])
        );
    end

    // Protection bits carry no meaning for this port
    // Upper strobes and data are dropped: no register is wider than 16 bits
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot,
                           w_strb_q[3:2], w_data_q[31:16]};

endmodule : pdpc_port

// ==== tb/pdpc_board_model.sv ====
// Board model: pins wired to LEDs and resistors beside the port.
// Assumes the enables are active high; an undriven, unpulled pin rests at float_lvl.
module pdpc_board_model (
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    input wire logic [7:0] drive_hi_en,
    input wire logic [7:0] drive_lo_en,
    input wire logic       float_lvl,
    output logic     [7:0] pad_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Low driver wins, as an LED sinks through it; pulls only when undriven
    assign pad_i = ~drive_lo_en & (drive_hi_en | pull_up_en
                   | (~pull_down_en & {8{float_lvl}}));
endmodule : pdpc_board_model

// ==== tb/pdpc_port_sva.sv ====
// Checker for pdpc_port: bus answer timing and pad enable decode.
// Assumes it is bound to pdpc_port and sees only its ports.
module pdpc_port_sva #(
    parameter int PINS = 8  // Pins of the port
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [PINS-1:0] pad_o,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pull_up_en,
    input wire logic [PINS-1:0] pull_down_en,
    input wire logic [PINS-1:0] drive_hi_en,
    input wire logic [PINS-1:0] drive_lo_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    write_answer_a: assert property ((wr_taken ##0 !s_axi_bvalid)
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");

    ////////////////////////////////////////////////////////////////////////////
    // Pad enables
    reset_clear_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && (pull_up_en | pull_down_en | drive_hi_en | drive_lo_en) == '0)
        else $error("state not cleared by reset");
    hi_lo_excl_a: assert property ((drive_hi_en & drive_lo_en) == '0)
        else $error("both drivers on");
    pull_excl_a: assert property ((pull_up_en & pull_down_en) == '0)
        else $error("both pulls on");
    pull_drive_excl_a: assert property
        (((pull_up_en | pull_down_en) & (drive_hi_en | drive_lo_en)) == '0)
        else $error("pull and driver together");
    pad_level_a: assert property (pad_o == drive_hi_en
        && pad_oe == (drive_hi_en | drive_lo_en)) else $error("pad level mismatch");
endmodule : pdpc_port_sva

bind pdpc_port pdpc_port_sva #(.PINS(PINS)) i_pdpc_port_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pad_o(pad_o), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .drive_hi_en(drive_hi_en),
    .drive_lo_en(drive_lo_en));

// ==== tb/pdpc_port_tb_top.sv ====
// Testbench for pdpc_port: AXI4-Lite master tasks, row table, hand tests.
// Assumes pdpc_defines.svh on the include path and the board model beside.
`include "pdpc_defines.svh"

module pdpc_port_tb_top
    import pdpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [7:0] dir, dat, pu, pd, hi, lo, rd; } pdpc_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rv;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  alt_out = '0, alt_en = '0, pad_i, pad_o, pad_oe, pu, pd, hi, lo;
    int          num_errors = 0, n_checks = 0;
    // Pin n code is n mod 4, so each code appears twice per row
    pdpc_row_t rows [5] = '{'{8'h00, 8'hF0, 8'h00, 8'h00, 8'hA0, 8'h0C, 8'hF0},
                            '{8'hFF, 8'hF0, 8'h44, 8'h22, 8'h00, 8'h00, 8'hDD},
                            '{8'h0F, 8'hF0, 8'h04, 8'h02, 8'hA0, 8'h00, 8'hFD},
                            '{8'hF0, 8'h0F, 8'h40, 8'h20, 8'h0A, 8'h00, 8'hDF},
                            '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hCC, 8'h00}};

    pdpc_port i_pdpc_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alt_out(alt_out), .alt_out_en(alt_en),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .pull_up_en(pu), .pull_down_en(pd),
        .drive_hi_en(hi), .drive_lo_en(lo));
    pdpc_board_model i_pdpc_board_model (.pull_up_en(pu), .pull_down_en(pd),
        .drive_hi_en(hi), .drive_lo_en(lo), .float_lvl(1'b1), .pad_i(pad_i));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 50 MHz
    initial begin
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write one word; both channels offered together, waits only for the answer
    // With late set, the ready is raised only after the answer is seen
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s,
                      input bit late = 1'b0);
        @(posedge aclk);
        awaddr <= {idx, 2'b00}; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= !late;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0; rs = bresp; break;
            end else if (bvalid) bready <= 1'b1;
        end
    endtask : wr

    task automatic rd(input logic [15:0] idx, input bit late = 1'b0);
        @(posedge aclk);
        araddr <= {idx, 2'b00}; arvalid <= 1'b1; rready <= !late;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0; rv = rdata; rs = rresp; break;
            end else if (rvalid) rready <= 1'b1;
        end
    endtask : rd

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PDPC_IDX_DIR); chk(rv, 32'h0);
        rd(`PDPC_IDX_CON); chk(rv, 32'h0);
        chk({pu, pd, hi, lo}, 32'h0);
        wr(`PDPC_IDX_CON, 32'h0000_CCAA, 4'h3);
        rd(`PDPC_IDX_CON); chk(rv, 32'h0000_CCAA);
        rd(`PDPC_IDX_CON_HI); chk(rv, 32'h0000_00CC);
        foreach (rows[i]) begin
            wr(`PDPC_IDX_DIR, {24'h0, rows[i].dir}, 4'h1);
            wr(`PDPC_IDX_DATA, {24'h0, rows[i].dat}, 4'h1);
            @(posedge aclk);
            #1 chk({pu, pd, hi, lo}, {rows[i].pu, rows[i].pd, rows[i].hi, rows[i].lo});
            chk({pu, pd}, {rows[i].pu, rows[i].pd});
            rd(`PDPC_IDX_DATA); chk(rv, {24'h0, rows[i].rd});
            rd(`PDPC_IDX_DIR); chk(rv, {24'h0, rows[i].dir});
        end
        // High byte alone must leave the low byte untouched
        wr(`PDPC_IDX_CON, 32'h0000_3300, 4'h2);
        rd(`PDPC_IDX_CON); chk(rv, 32'h0000_33AA);
        wr(16'hF236, 32'h0000_00FF, 4'hF); chk(rs, 2'h2);
        rd(16'hF236); chk(rv, 32'h0);
        chk(rs, 2'h2);
        // Pin 0 is an N-channel output driving low; handing it to a peripheral drives it high
        alt_en <= 8'h01; alt_out <= 8'h01;
        wr(`PDPC_IDX_FSEL, 32'h0000_0001, 4'h3);
        repeat (2) @(posedge aclk);
        #1 chk({hi[0], lo[0], pu[0], pd[0]}, 4'b1000);
        // Second reset mid-run
        @(posedge aclk); aresetn <= 1'b0;
        repeat (2) @(posedge aclk); aresetn <= 1'b1;
        rd(`PDPC_IDX_DIR); chk(rv, 32'h0);
        rd(`PDPC_IDX_CON); chk(rv, 32'h0);
        chk({pu, pd, hi, lo}, 32'h0);
        // Late acceptance of both answers; the slave must hold them
        wr(`PDPC_IDX_DIR, 32'h0000_005A, 4'h1, 1'b1); chk(rs, 2'h0);
        rd(`PDPC_IDX_DIR, 1'b1); chk(rv, 32'h0000_005A);
        // High byte written alone at its own index
        wr(`PDPC_IDX_CON_HI, 32'h0000_0055, 4'h1);
        rd(`PDPC_IDX_CON); chk(rv, 32'h0000_5500);
        report_and_stop();
    end
endmodule : pdpc_port_tb_top
